// [rtl/csu_pkg.sv]
// Constants, abort codes and state encoding for the SDO upload server.
// Assumes 8-byte CAN payloads with byte 0 in bits 7:0.
package csu_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int        CSU_FRAME_W      = 64;
    localparam int        CSU_TOGGLE_BIT   = 4;
    localparam int        CSU_ACCESS_BIT   = 4;
    localparam int        CSU_EXPED_BIT    = 1;
    localparam logic [2:0] CSU_CCS_DOWN    = 3'h1;
    localparam logic [2:0] CSU_CCS_INIT_UP = 3'h2;
    localparam logic [2:0] CSU_CCS_SEG_UP  = 3'h3;
    localparam logic [7:0] CSU_CMD_ABORT   = 8'h80;
    localparam logic [7:0] CSU_CMD_UP_RSP  = 8'h41;
    localparam logic [7:0] CSU_CMD_DN_RSP  = 8'h60;
    localparam logic [2:0] CSU_SEG_RSP_CCS = 3'h0;
    localparam logic [3:0] CSU_SEG_ZERO    = 4'h0;
    localparam logic [2:0] CSU_SEG_BYTES   = 3'h7;
    localparam logic [3:0] CSU_FETCH_LAST  = 4'h7;
    localparam logic [2:0] CSU_EXP_BYTES   = 3'h4;

    // ****************************************
    // Process-data parameter objects
    // ****************************************
    localparam logic [7:0] CSU_PDO_RX_COM  = 8'h14;
    localparam logic [7:0] CSU_PDO_RX_MAP  = 8'h16;
    localparam logic [7:0] CSU_PDO_TX_COM  = 8'h18;
    localparam logic [7:0] CSU_PDO_TX_MAP  = 8'h1a;

    // ****************************************
    // Abort codes
    // ****************************************
    localparam logic [31:0] CSU_ERR_TOGGLE    = 32'h0503_0000;
    localparam logic [31:0] CSU_ERR_COMMAND   = 32'h0504_0001;
    localparam logic [31:0] CSU_ERR_ACCESS    = 32'h0601_0000;
    localparam logic [31:0] CSU_ERR_READONLY  = 32'h0601_0002;
    localparam logic [31:0] CSU_ERR_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] CSU_ERR_NO_MAP    = 32'h0604_0041;
    localparam logic [31:0] CSU_ERR_MAP_LEN   = 32'h0604_0042;
    localparam logic [31:0] CSU_ERR_LEN_HIGH  = 32'h0607_0012;
    localparam logic [31:0] CSU_ERR_LEN_LOW   = 32'h0607_0013;
    localparam logic [31:0] CSU_ERR_NO_SUB    = 32'h0609_0011;
    localparam logic [31:0] CSU_ERR_VAL_HIGH  = 32'h0609_0031;
    localparam logic [31:0] CSU_ERR_VAL_LOW   = 32'h0609_0032;
    localparam logic [31:0] CSU_ERR_GENERAL   = 32'h0800_0000;
    localparam logic [31:0] CSU_ERR_STATE     = 32'h0800_0022;
    localparam logic [31:0] CSU_ERR_NONE      = 32'h0000_0000;

    typedef enum logic [1:0] {
        CSU_IDLE   = 2'b00,
        CSU_DECODE = 2'b01,
        CSU_FETCH  = 2'b11,
        CSU_SEND   = 2'b10
    } csu_state_t;

endpackage

// [rtl/csu_buf2.sv]
// Two-entry valid/ready buffer for response frames.
// Assumes one clock; the consumer may hold ready low for any time.
`timescale 1ns/1ps
module csu_buf2 #(
    parameter int WIDTH = 64
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // ****************************************
    // Storage
    // ****************************************
    logic [1:0][WIDTH-1:0] mem_reg;
    logic                  wr_ptr_reg;
    logic                  rd_ptr_reg;
    logic [1:0]            count_reg;
    logic                  push;
    logic                  pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_reg <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule

// [rtl/csu_server.sv]
// SDO server: segmented upload, expedited download checks and aborts.
// Assumes the object dictionary answers lookups combinationally and
// byte reads one cycle after the address.
`timescale 1ns/1ps

// Behaviour
// - Response toggle equals request toggle; the expected toggle flips per pair.
// - Every upload starts with expected toggle zero, also after an abort.
// - Segment response bits 3..1 give the count of unused trailing bytes.
// - No-more-segments bit set only on the final segment.
// - Initiate answer is 41h, echoes index and subindex, gives byte count.
// - Non-final segments carry seven payload bytes with the flag clear.
// - Final segment sets the flag and counts its unused bytes.
// - Abort frame is 80h, index, subindex, 32-bit code.
// - A received abort ends the transfer silently; restart needs initiate.
// - Client aborts are taken with any or no code; code is ignored.
// - Unchanged toggle aborts with 05030000h.
// - Unknown command byte aborts with 05040001h.
// - Write to read-only entry aborts with 06010002h.
// - Missing index aborts with 06020000h.
// - Missing subindex of an existing index aborts with 06090011h.
// - Write too long aborts 06070012h, too short aborts 06070013h.
// - Value above range aborts 06090031h, below range 06090032h.
// - Unmappable object aborts 06040041h, mapping overflow 06040042h.
// - PDO parameter writes while Operational abort with 08000022h.
// - Other failures abort with 08000000h; a segment request with no upload open aborts with 05040001h.
// - Complete-access requests abort with 06010000h.
module csu_server
    import csu_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [63:0] rx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [63:0] tx_data,
    input  wire logic        nmt_operational,
    output logic      [15:0] od_index,
    output logic      [7:0]  od_subidx,
    input  wire logic        od_index_ok,
    input  wire logic        od_subidx_ok,
    input  wire logic [31:0] od_size,
    input  wire logic        od_read_only,
    input  wire logic [31:0] od_value_max,
    input  wire logic [31:0] od_value_min,
    input  wire logic        od_map_refused,
    input  wire logic        od_map_overflow,
    input  wire logic        od_fault,
    output logic      [31:0] od_rd_addr,
    input  wire logic [7:0]  od_rd_data,
    output logic             od_wr_strobe,
    output logic      [31:0] od_wr_value,
    output logic             upload_busy,
    output logic      [31:0] last_abort_code
);

    // ****************************************
    // Request capture and context
    // ****************************************
    csu_state_t      state_reg;
    logic [7:0]      req_cmd_reg;
    logic [15:0]     req_index_reg;
    logic [7:0]      req_sub_reg;
    logic [31:0]     req_data_reg;
    logic            ctx_active_reg;
    logic [15:0]     ctx_index_reg;
    logic [7:0]      ctx_sub_reg;
    logic [31:0]     ctx_size_reg;
    logic [31:0]     ctx_offset_reg;
    logic            ctx_toggle_reg;
    logic [3:0]      fetch_cnt_reg;
    logic [6:0][7:0] seg_bytes_reg;
    logic            resp_push_reg;
    logic [63:0]     resp_frame_reg;
    logic            buf_in_ready;
    logic            rx_take;

    assign rx_ready    = (state_reg == CSU_IDLE) && buf_in_ready && !resp_push_reg;
    assign rx_take     = rx_valid && rx_ready;
    assign upload_busy = ctx_active_reg;
    assign od_index    = (state_reg == CSU_DECODE) ? req_index_reg : ctx_index_reg;
    assign od_subidx   = (state_reg == CSU_DECODE) ? req_sub_reg : ctx_sub_reg;
    assign od_rd_addr  = ctx_offset_reg + {28'h0, fetch_cnt_reg};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_cmd_reg   <= 8'h00;
            req_index_reg <= 16'h0000;
            req_sub_reg   <= 8'h00;
            req_data_reg  <= 32'h0000_0000;
        end else if (rx_take) begin
            req_cmd_reg   <= rx_data[7:0];
            req_index_reg <= rx_data[23:8];
            req_sub_reg   <= rx_data[31:24];
            req_data_reg  <= rx_data[63:32];
        end
    end

    // ****************************************
    // Decode of a captured request
    // ****************************************
    logic [2:0]  ccs;
    logic        req_toggle;
    logic [2:0]  wr_bytes;
    logic        pdo_param;
    logic        dec_abort;
    logic [31:0] dec_code;
    logic        dec_init;
    logic        dec_seg;
    logic        dec_write;
    logic        dec_silent;

    assign ccs        = req_cmd_reg[7:5];
    assign req_toggle = req_cmd_reg[CSU_TOGGLE_BIT];
    assign wr_bytes   = CSU_EXP_BYTES - {1'b0, req_cmd_reg[3:2]};
    assign pdo_param  = (req_index_reg[7:3] == 5'h00) &&
                        (req_index_reg[15:8] == CSU_PDO_RX_COM ||
                         req_index_reg[15:8] == CSU_PDO_RX_MAP ||
                         req_index_reg[15:8] == CSU_PDO_TX_COM ||
                         req_index_reg[15:8] == CSU_PDO_TX_MAP);

    always_comb begin
        dec_abort  = 1'b0;
        dec_code   = CSU_ERR_NONE;
        dec_init   = 1'b0;
        dec_seg    = 1'b0;
        dec_write  = 1'b0;
        dec_silent = 1'b0;
        if (req_cmd_reg == CSU_CMD_ABORT) begin
            dec_silent = 1'b1;
        end else if (ccs == CSU_CCS_INIT_UP) begin
            dec_abort = 1'b1;
            if (req_cmd_reg[CSU_ACCESS_BIT]) begin
                dec_code = CSU_ERR_ACCESS;
            end else if (!od_index_ok) begin
                dec_code = CSU_ERR_NO_OBJECT;
            end else if (!od_subidx_ok) begin
                dec_code = CSU_ERR_NO_SUB;
            end else if (od_fault) begin
                dec_code = CSU_ERR_GENERAL;
            end else begin
                dec_abort = 1'b0;
                dec_init  = 1'b1;
            end
        end else if (ccs == CSU_CCS_SEG_UP) begin
            dec_abort = 1'b1;
            if (req_cmd_reg[3:0] != CSU_SEG_ZERO || !ctx_active_reg) begin
                dec_code = CSU_ERR_COMMAND;
            end else if (req_toggle != ctx_toggle_reg) begin
                dec_code = CSU_ERR_TOGGLE;
            end else begin
                dec_abort = 1'b0;
                dec_seg   = 1'b1;
            end
        end else if (ccs == CSU_CCS_DOWN) begin
            dec_abort = 1'b1;
            if (req_cmd_reg[CSU_ACCESS_BIT]) begin
                dec_code = CSU_ERR_ACCESS;
            end else if (nmt_operational && pdo_param) begin
                dec_code = CSU_ERR_STATE;
            end else if (!od_index_ok) begin
                dec_code = CSU_ERR_NO_OBJECT;
            end else if (!od_subidx_ok) begin
                dec_code = CSU_ERR_NO_SUB;
            end else if (od_read_only) begin
                dec_code = CSU_ERR_READONLY;
            end else if (!req_cmd_reg[CSU_EXPED_BIT]) begin
                dec_code = CSU_ERR_GENERAL;
            end else if ({29'h0, wr_bytes} > od_size) begin
                dec_code = CSU_ERR_LEN_HIGH;
            end else if ({29'h0, wr_bytes} < od_size) begin
                dec_code = CSU_ERR_LEN_LOW;
            end else if (req_data_reg > od_value_max) begin
                dec_code = CSU_ERR_VAL_HIGH;
            end else if (req_data_reg < od_value_min) begin
                dec_code = CSU_ERR_VAL_LOW;
            end else if (od_map_refused) begin
                dec_code = CSU_ERR_NO_MAP;
            end else if (od_map_overflow) begin
                dec_code = CSU_ERR_MAP_LEN;
            end else if (od_fault) begin
                dec_code = CSU_ERR_GENERAL;
            end else begin
                dec_abort = 1'b0;
                dec_write = 1'b1;
            end
        end else begin
            dec_abort = 1'b1;
            dec_code  = CSU_ERR_COMMAND;
        end
    end

    // ****************************************
    // Segment sizing
    // ****************************************
    logic [31:0] remaining;
    logic        seg_last;
    logic [2:0]  seg_valid;
    logic [2:0]  fetch_idx;

    assign remaining = ctx_size_reg - ctx_offset_reg;
    assign seg_last  = (remaining <= {29'h0, CSU_SEG_BYTES});
    assign seg_valid = seg_last ? remaining[2:0] : CSU_SEG_BYTES;
    assign fetch_idx = fetch_cnt_reg[2:0] - 3'h1;

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CSU_IDLE;
        end else begin
            unique case (state_reg)
                CSU_IDLE: begin
                    if (rx_take) begin
                        state_reg <= CSU_DECODE;
                    end
                end
                CSU_DECODE: begin
                    state_reg <= dec_seg ? CSU_FETCH : CSU_IDLE;
                end
                CSU_FETCH: begin
                    if (fetch_cnt_reg == CSU_FETCH_LAST) begin
                        state_reg <= CSU_SEND;
                    end
                end
                CSU_SEND: begin
                    state_reg <= CSU_IDLE;
                end
            endcase
        end
    end

    // Reads run one byte ahead; the tail beyond the object is zeroed
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fetch_cnt_reg <= 4'h0;
            seg_bytes_reg <= '0;
        end else if (state_reg == CSU_FETCH) begin
            fetch_cnt_reg <= fetch_cnt_reg + 4'h1;
            if (fetch_cnt_reg != 4'h0) begin
                seg_bytes_reg[fetch_idx] <= (fetch_idx < seg_valid) ? od_rd_data : 8'h00;
            end
        end else begin
            fetch_cnt_reg <= 4'h0;
        end
    end

    // ****************************************
    // Upload context
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctx_active_reg <= 1'b0;
            ctx_index_reg  <= 16'h0000;
            ctx_sub_reg    <= 8'h00;
            ctx_size_reg   <= 32'h0000_0000;
            ctx_offset_reg <= 32'h0000_0000;
            ctx_toggle_reg <= 1'b0;
        end else if (state_reg == CSU_DECODE) begin
            if (dec_init) begin
                ctx_active_reg <= 1'b1;
                ctx_index_reg  <= req_index_reg;
                ctx_sub_reg    <= req_sub_reg;
                ctx_size_reg   <= od_size;
                ctx_offset_reg <= 32'h0000_0000;
                ctx_toggle_reg <= 1'b0;
            end else if (dec_abort || dec_silent) begin
                ctx_active_reg <= 1'b0;
                ctx_toggle_reg <= 1'b0;
            end
        end else if (state_reg == CSU_SEND) begin
            ctx_offset_reg <= ctx_offset_reg + {29'h0, seg_valid};
            ctx_toggle_reg <= ~ctx_toggle_reg;
            if (seg_last) begin
                ctx_active_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Responses and object writes
    // ****************************************
    // Abort pushes happen only after a taken request, so the buffer has room
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resp_push_reg  <= 1'b0;
            resp_frame_reg <= 64'h0;
        end else begin
            resp_push_reg <= 1'b0;
            if (state_reg == CSU_DECODE && dec_abort) begin
                resp_push_reg  <= 1'b1;
                resp_frame_reg <= {dec_code, req_sub_reg, req_index_reg, CSU_CMD_ABORT};
            end else if (state_reg == CSU_DECODE && dec_init) begin
                resp_push_reg  <= 1'b1;
                resp_frame_reg <= {od_size, req_sub_reg, req_index_reg, CSU_CMD_UP_RSP};
            end else if (state_reg == CSU_DECODE && dec_write) begin
                resp_push_reg  <= 1'b1;
                resp_frame_reg <= {32'h0, req_sub_reg, req_index_reg, CSU_CMD_DN_RSP};
            end else if (state_reg == CSU_SEND) begin
                resp_push_reg  <= 1'b1;
                resp_frame_reg <= {seg_bytes_reg, CSU_SEG_RSP_CCS, ctx_toggle_reg,
                                   CSU_SEG_BYTES - seg_valid, seg_last};
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            od_wr_strobe    <= 1'b0;
            od_wr_value     <= 32'h0000_0000;
            last_abort_code <= CSU_ERR_NONE;
        end else begin
            od_wr_strobe <= (state_reg == CSU_DECODE) && dec_write;
            if (state_reg == CSU_DECODE && dec_write) begin
                od_wr_value <= req_data_reg;
            end
            if (state_reg == CSU_DECODE && dec_abort) begin
                last_abort_code <= dec_code;
            end
        end
    end

    csu_buf2 #(
        .WIDTH (CSU_FRAME_W)
    ) u_resp_buf (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (resp_push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (resp_frame_reg),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence seg_taken_s;
        rx_take && rx_data[7:5] == CSU_CCS_SEG_UP;
    endsequence

    sequence seg_pushed_s;
        resp_push_reg && resp_frame_reg[7:5] == CSU_SEG_RSP_CCS;
    endsequence

    a_seg_toggle_echo: assert property (@(posedge clock) disable iff (!rstn)
        resp_push_reg && resp_frame_reg[7:5] == CSU_SEG_RSP_CCS
        |-> resp_frame_reg[CSU_TOGGLE_BIT] == req_cmd_reg[CSU_TOGGLE_BIT])
        else $error("segment toggle not echoed");

    a_init_toggle_zero: assert property (@(posedge clock) disable iff (!rstn)
        resp_push_reg && resp_frame_reg[7:0] == CSU_CMD_UP_RSP |-> !ctx_toggle_reg)
        else $error("upload did not start with toggle zero");

    a_mid_seg_full: assert property (@(posedge clock) disable iff (!rstn)
        seg_pushed_s and (resp_frame_reg[7:5] == CSU_SEG_RSP_CCS && !resp_frame_reg[0])
        |-> resp_frame_reg[3:1] == 3'h0)
        else $error("non-final segment not full");

    a_last_seg_end: assert property (@(posedge clock) disable iff (!rstn)
        $rose(resp_push_reg) && resp_frame_reg[7:5] == CSU_SEG_RSP_CCS
        && resp_frame_reg[0] |-> !ctx_active_reg)
        else $error("context kept after last segment");

    a_init_size: assert property (@(posedge clock) disable iff (!rstn)
        resp_push_reg && resp_frame_reg[7:0] == CSU_CMD_UP_RSP
        |-> resp_frame_reg[63:32] == ctx_size_reg && ctx_active_reg)
        else $error("initiate answer size wrong");

    a_abort_silent: assert property (@(posedge clock) disable iff (!rstn)
        rx_take && rx_data[7:0] == CSU_CMD_ABORT |=> !resp_push_reg [*2] ##0 !ctx_active_reg)
        else $error("abort was answered or context kept");

    a_toggle_abort: assert property (@(posedge clock) disable iff (!rstn)
        state_reg == CSU_DECODE && dec_code == CSU_ERR_TOGGLE
        |=> resp_push_reg && resp_frame_reg[63:32] == CSU_ERR_TOGGLE && !ctx_active_reg)
        else $error("toggle error not aborted");

    a_pdo_lock: assert property (@(posedge clock) disable iff (!rstn)
        state_reg == CSU_DECODE && ccs == CSU_CCS_DOWN && !req_cmd_reg[CSU_ACCESS_BIT]
        && nmt_operational && pdo_param |=> !od_wr_strobe)
        else $error("PDO parameter written while operational");

    a_seg_latency: assert property (@(posedge clock) disable iff (!rstn)
        seg_taken_s |-> ##[2:12] resp_push_reg)
        else $error("segment request not answered in time");

endmodule

// [test/csu_od_model.sv]
// Object dictionary stand-in for the upload server.
// Assumes lookups are combinational and byte reads lag the address by one cycle.
`timescale 1ns/1ps
module csu_od_model (
    input  wire logic        clock,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_subidx,
    input  wire logic [31:0] od_rd_addr,
    output logic             od_index_ok,
    output logic             od_subidx_ok,
    output logic      [31:0] od_size,
    output logic             od_read_only,
    output logic      [31:0] od_value_max,
    output logic      [31:0] od_value_min,
    output logic             od_map_refused,
    output logic             od_map_overflow,
    output logic             od_fault,
    output logic      [7:0]  od_rd_data
);
    // A 30-byte string, a zero-only counter and one mapping object
    // Mapping subindices 1 to 3 trip the mapping and fault checks
    assign od_index_ok     = od_index inside {16'h1009, 16'h1003, 16'h1600};
    assign od_subidx_ok    = od_subidx == 8'h00 || (od_index == 16'h1600 && od_subidx < 8'h04);
    assign od_size         = (od_index == 16'h1009) ? 32'h1e :
                             (od_index == 16'h1003) ? 32'h01 : 32'h04;
    assign od_read_only    = od_index == 16'h1009;
    assign od_value_max    = (od_index == 16'h1600) ? 32'hffff_ffff : 32'h0;
    assign od_value_min    = (od_index == 16'h1600) ? 32'h10 : 32'h0;
    assign od_map_refused  = od_index == 16'h1600 && od_subidx == 8'h01;
    assign od_map_overflow = od_index == 16'h1600 && od_subidx == 8'h02;
    assign od_fault        = od_index == 16'h1600 && od_subidx == 8'h03;
    always_ff @(posedge clock) od_rd_data <= od_rd_addr[7:0] ^ 8'ha5;
endmodule

// [test/tb_csu_server.sv]
// Self-checking bench for the upload server, acting as the client.
// Assumes the dictionary model above; responses are stalled at random.
`timescale 1ns/1ps
module tb_csu_server;
    import csu_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, nmt_operational = 1'b0;
    logic [63:0] rx_data = 64'h0, tx_data, q[$], reqs[15];
    logic [31:0] codes[15], od_rd_addr, last_abort_code, od_size, od_value_max, od_value_min;
    logic [31:0] od_wr_value;
    logic [15:0] od_index;
    logic [7:0]  od_subidx, od_rd_data, rv;
    logic rx_ready, tx_valid, od_index_ok, od_subidx_ok, od_read_only, upload_busy;
    logic od_map_refused, od_map_overflow, od_fault, od_wr_strobe;
    int seed = 32'he27b39dd, n_errors = 0, compares = 0, s, n_wr = 0;
    csu_server u_csu_server (.clock(clock), .rstn(rstn), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .nmt_operational(nmt_operational), .od_index(od_index),
        .od_subidx(od_subidx), .od_index_ok(od_index_ok), .od_subidx_ok(od_subidx_ok),
        .od_size(od_size), .od_read_only(od_read_only), .od_value_max(od_value_max),
        .od_value_min(od_value_min), .od_map_refused(od_map_refused),
        .od_map_overflow(od_map_overflow), .od_fault(od_fault), .od_rd_addr(od_rd_addr),
        .od_rd_data(od_rd_data), .od_wr_strobe(od_wr_strobe), .od_wr_value(od_wr_value),
        .upload_busy(upload_busy), .last_abort_code(last_abort_code));
    csu_od_model u_csu_od_model (.*);
    always #2.5 clock = ~clock;
    // Random stalls check that the buffer holds frames
    always @(posedge clock) tx_ready <= ($random(seed) & 3) != 0;
    always @(posedge clock) if (rstn && tx_valid && tx_ready) q.push_back(tx_data);
    always @(posedge clock) if (rstn && od_wr_strobe === 1'b1) n_wr++;
    function automatic logic [63:0] rq(input logic [7:0] c, input logic [15:0] x,
                                       input logic [7:0] b, input logic [31:0] v);
        return {v, b, x, c};
    endfunction
    task automatic final_report();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic send(input logic [63:0] f);
        int i;
        i = 0;
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_data  <= f;
        do begin @(negedge clock); i++; end while (rx_ready !== 1'b1 && i < 60);
        if (rx_ready !== 1'b1) begin n_errors++; final_report(); end
        @(posedge clock);
        rx_valid <= 1'b0;
    endtask
    task automatic get(input logic [63:0] e, input string n);
        int i;
        i = 0;
        while (q.size() == 0 && i < 60) begin @(negedge clock); i++; end
        if (q.size() == 0) begin n_errors++; final_report(); end
        chk(n, q.pop_front(), e);
    endtask
    // Expected segment from the segment number: seven bytes, fewer on the last
    task automatic seg(input int g, input int t);
        int v, k;
        logic [63:0] e;
        v = (30 - 7 * g > 7) ? 7 : 30 - 7 * g;
        e = 64'(t * 16 + (7 - v) * 2 + ((7 * g + v == 30) ? 1 : 0));
        for (k = 1; k <= v; k++) e[8*k +: 8] = 8'(7 * g + k - 1) ^ 8'ha5;
        send(rq(8'(8'h60 + t * 16), 16'h1009, 8'h00, 32'h0));
        get(e, "segment");
    endtask
    task automatic init();
        send(rq(8'h40, 16'h1009, 8'h00, 32'h0));
        get(64'h0000_001e_0010_0941, "initiate");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        init();
        for (s = 0; s < 5; s++) seg(s, s % 2);
        chk("busy", upload_busy, 64'h0);
        $display("test upload done");
        init();
        seg(0, 0);
        send(rq(8'h60, 16'h1009, 8'h00, 32'h0));
        get(rq(8'h80, 16'h1009, 8'h00, CSU_ERR_TOGGLE), "toggle");
        chk("code", last_abort_code, 64'(CSU_ERR_TOGGLE));
        init();
        seg(0, 0);
        send(rq(8'h80, 16'h1009, 8'h00, 32'h0));
        repeat (20) @(negedge clock);
        chk("silence", 64'(q.size()), 64'h0);
        init();
        seg(0, 0);
        $display("test abort done");
        rv = 8'($random(seed)) | 8'h01;
        // The first eight run while Operational, the rest while not
        reqs = '{rq(8'h40, 16'h2000, 8'h00, 0), rq(8'h40, 16'h1009, 8'h01, 0),
                 rq(8'he0, 16'h1009, 8'h00, 0), rq(8'h50, 16'h1009, 8'h00, 0),
                 rq(8'h2f, 16'h1009, 8'h00, 1), rq(8'h2f, 16'h1003, 8'h00, {24'h0, rv}),
                 rq(8'h23, 16'h1600, 8'h00, 0), rq(8'h23, 16'h1003, 8'h00, 0),
                 rq(8'h2f, 16'h1600, 8'h00, 32), rq(8'h23, 16'h1600, 8'h00, {28'h0, rv[3:0]}),
                 rq(8'h23, 16'h1600, 8'h01, 32), rq(8'h23, 16'h1600, 8'h02, 32),
                 rq(8'h40, 16'h1600, 8'h03, 0), rq(8'h21, 16'h1003, 8'h00, 0),
                 rq(8'h61, 16'h1009, 8'h00, 0)};
        codes = '{CSU_ERR_NO_OBJECT, CSU_ERR_NO_SUB, CSU_ERR_COMMAND, CSU_ERR_ACCESS,
                  CSU_ERR_READONLY, CSU_ERR_VAL_HIGH, CSU_ERR_STATE, CSU_ERR_LEN_HIGH,
                  CSU_ERR_LEN_LOW, CSU_ERR_VAL_LOW, CSU_ERR_NO_MAP, CSU_ERR_MAP_LEN,
                  CSU_ERR_GENERAL, CSU_ERR_GENERAL, CSU_ERR_COMMAND};
        for (s = 0; s < 15; s++) begin
            @(posedge clock);
            nmt_operational <= (s < 8);
            send(reqs[s]);
            get(rq(8'h80, reqs[s][23:8], reqs[s][31:24], codes[s]), "abort");
        end
        send(rq(8'h23, 16'h1600, 8'h00, 32'h20));
        get(rq(8'h60, 16'h1600, 8'h00, 0), "write");
        chk("wr_value", od_wr_value, 64'h20);
        chk("writes", 64'(n_wr), 64'h1);
        $display("test error codes done");
        final_report();
    end
endmodule
